// [rtl/lane_link_status_bank.sv]
// lane link status bank: paged per-lane status bytes behind an AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lls_defines.svh"

module lane_link_status_bank #(
	parameter int ADDR_W    = 16,  // byte address width
	parameter int NUM_LINKS = 2    // number of pageable links
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// write address channel
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// write data channel
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// write response channel
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// read address channel
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// read data channel
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// link page select and error threshold from the shared control bank
	// width written out here: the page localparam is only declared in the body
	input  wire logic [((NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1)-1:0] link_page,
	input  wire logic [`LLS_THR_W-1:0] error_count_threshold,
	input  wire logic                  err_count_clear,
	// per-link, per-lane datapath status; lane index 0 is lane 1
	input  wire lls_pkg::lls_lane_in_s lane_in [NUM_LINKS][3],
	// level interrupt
	output logic                       irq
);

	localparam int PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;
	localparam int IDX_W  = ADDR_W - 2;

	// lane bytes of every link
	lls_pkg::lls_status_s       lane_status [NUM_LINKS][3];
	logic [NUM_LINKS-1:0]       lane_changed [3];  // per lane, per link

	// page register, sampled so reads see one stable page
	logic [PAGE_W-1:0]          page_q;

	// write side holding flops
	logic                       aw_held_q;   // address taken, waiting data
	logic [IDX_W-1:0]           aw_idx_q;    // word index of the write
	logic                       w_held_q;    // data taken, waiting address
	logic [31:0]                wdata_q;     // held write data
	logic [3:0]                 wstrb_q;     // held byte enables
	logic                       awready_q;
	logic                       wready_q;
	logic                       bvalid_q;
	logic [1:0]                 bresp_q;

	// read side flops
	logic                       arready_q;
	logic                       rvalid_q;
	logic [31:0]                rdata_q;
	logic [1:0]                 rresp_q;

	// interrupt registers
	logic [`LLS_IRQ_W-1:0]      irq_stat_q;
	logic [`LLS_IRQ_W-1:0]      irq_stat_d;
	logic [`LLS_IRQ_W-1:0]      irq_mask_q;
	logic                       irq_q;

	// decode helpers
	logic [IDX_W-1:0]           ar_idx;      // read word index
	logic                       ar_take;     // read address accepted now
	logic                       wr_do;       // write performed now
	logic                       wr_mask_hit; // write targets the mask
	logic                       wr_known;    // write hits a mapped word
	logic [`LLS_IRQ_W-1:0]      lane_evt;    // any link's lane byte moved
	logic [31:0]                rd_data_d;
	logic [1:0]                 rd_resp_d;

	// one monitor per link per lane; all links keep running, page only
	// chooses which one software sees
	generate
		for (genvar g = 0; g < NUM_LINKS * 3; g++) begin : g_lane
			lls_lane_monitor #(
				.CNT_W       (`LLS_THR_W)
			) u_mon (
				.aclk        (aclk),
				.aresetn     (aresetn),
				.count_clear (err_count_clear),
				.threshold   (error_count_threshold),
				.lane_in     (lane_in[g/3][g%3]),
				.status_q    (lane_status[g/3][g%3]),
				.changed_q   (lane_changed[g%3][g/3])
			);
		end
	endgenerate

	// outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign irq           = irq_q;

	// page sample
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_q <= '0;
		end else begin
			page_q <= link_page;
		end
	end

	// write address channel: ready only while no address is held or answered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			aw_held_q <= 1'b0;
			aw_idx_q  <= '0;
		end else if (s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_held_q <= 1'b1;
			aw_idx_q  <= s_axi_awaddr[ADDR_W-1:2];
		end else if (wr_do) begin
			aw_held_q <= 1'b0;
		end else if (!aw_held_q && !bvalid_q) begin
			awready_q <= 1'b1;
		end
	end

	// write data channel: taken independently of the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_q <= 1'b0;
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (wr_do) begin
			w_held_q <= 1'b0;
		end else if (!w_held_q && !bvalid_q) begin
			wready_q <= 1'b1;
		end
	end

	// a write happens once both halves are held and no answer is pending
	assign wr_do       = aw_held_q && w_held_q && !bvalid_q;
	assign wr_mask_hit = (aw_idx_q == IDX_W'(`LLS_IDX_IRQ_MASK));
	// status bytes and the interrupt status accept writes but drop the data
	assign wr_known    = wr_mask_hit ||
	                     (aw_idx_q == IDX_W'(`LLS_IDX_LANE1)) ||
	                     (aw_idx_q == IDX_W'(`LLS_IDX_LANE2)) ||
	                     (aw_idx_q == IDX_W'(`LLS_IDX_LANE3)) ||
	                     (aw_idx_q == IDX_W'(`LLS_IDX_IRQ_STAT));

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `LLS_RESP_OKAY;
		end else if (wr_do) begin
			bvalid_q <= 1'b1;
			// read-only words answer okay; only unmapped words are errors
			bresp_q  <= wr_known ? `LLS_RESP_OKAY : `LLS_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// interrupt mask, the only software-written state; low byte lane only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= `LLS_IRQ_MASK_RST;
		end else if (wr_do && wr_mask_hit && wstrb_q[0]) begin
			irq_mask_q <= wdata_q[`LLS_IRQ_W-1:0];
		end
	end

	// read address decode
	assign ar_idx  = s_axi_araddr[ADDR_W-1:2];
	assign ar_take = s_axi_arvalid && arready_q;

	// read data mux; lane bytes come from the paged link
	always_comb begin
		rd_data_d = 32'h0000_0000;
		rd_resp_d = `LLS_RESP_OKAY;
		if (ar_idx == IDX_W'(`LLS_IDX_LANE1)) begin
			if (int'(page_q) < NUM_LINKS) begin
				rd_data_d[7:0] = lane_status[page_q][0];
			end
		end else if (ar_idx == IDX_W'(`LLS_IDX_LANE2)) begin
			if (int'(page_q) < NUM_LINKS) begin
				rd_data_d[7:0] = lane_status[page_q][1];
			end
		end else if (ar_idx == IDX_W'(`LLS_IDX_LANE3)) begin
			if (int'(page_q) < NUM_LINKS) begin
				rd_data_d[7:0] = lane_status[page_q][2];
			end
		end else if (ar_idx == IDX_W'(`LLS_IDX_IRQ_STAT)) begin
			rd_data_d[`LLS_IRQ_W-1:0] = irq_stat_q;
		end else if (ar_idx == IDX_W'(`LLS_IDX_IRQ_MASK)) begin
			rd_data_d[`LLS_IRQ_W-1:0] = irq_mask_q;
		end else begin
			// unmapped word: zero data and an error
			rd_resp_d = `LLS_RESP_SLVERR;
		end
	end

	// read address ready: one read in flight at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
		end else if (ar_take) begin
			arready_q <= 1'b0;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	// read data: captured at the accept edge, held until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= `LLS_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_data_d;
			rresp_q  <= rd_resp_d;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// any link's lane byte moving raises that lane's event
	always_comb begin
		for (int l = 0; l < 3; l++) begin
			lane_evt[l] = |lane_changed[l];
		end
	end

	// sticky status, cleared by a read of it; a new event in the same
	// cycle as the clearing read survives so nothing is lost
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (ar_take && (ar_idx == IDX_W'(`LLS_IDX_IRQ_STAT))) begin
			irq_stat_d = '0;
		end
		irq_stat_d = irq_stat_d | lane_evt;
	end

	// status flop and interrupt level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= `LLS_IRQ_STAT_RST;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_q      <= |(irq_stat_d & irq_mask_q);
		end
	end

endmodule : lane_link_status_bank

// [rtl/lls_defines.svh]
// lane link status bank: offsets, bit positions, reset values and codes
`ifndef LLS_DEFINES_SVH
`define LLS_DEFINES_SVH

// register indices; byte address is four times the index
`define LLS_IDX_LANE1     12'h4b1
`define LLS_IDX_LANE2     12'h4b2
`define LLS_IDX_LANE3     12'h4b3
`define LLS_IDX_IRQ_STAT  12'h4b8
`define LLS_IDX_IRQ_MASK  12'h4b9

// status byte bit positions
`define LLS_BIT_DISP      7
`define LLS_BIT_INVALID   6
`define LLS_BIT_STRAY     5
`define LLS_BIT_DESKEW    4
`define LLS_BIT_ALIGN     3
`define LLS_BIT_CHECKSUM  2
`define LLS_BIT_FRAME     1
`define LLS_BIT_SYMBOL    0

// interrupt bit positions, one per lane byte
`define LLS_IRQ_LANE1     0
`define LLS_IRQ_LANE2     1
`define LLS_IRQ_LANE3     2
`define LLS_IRQ_W         3

// widths and reset values
`define LLS_THR_W         8
`define LLS_STATUS_RST    8'h00
`define LLS_IRQ_STAT_RST  3'h0
`define LLS_IRQ_MASK_RST  3'h0
`define LLS_CNT_RST       8'h00

// bus response codes
`define LLS_RESP_OKAY     2'h0
`define LLS_RESP_SLVERR   2'h2

`endif

// [rtl/lls_pkg.sv]
// lane link status bank: shared types
package lls_pkg;

	// per-lane inputs from the receive datapath of one link
	typedef struct packed {
		logic disp_err;          // one-cycle pulse per bad-disparity symbol
		logic invalid_sym;       // one-cycle pulse per symbol not in table
		logic stray_ctrl;        // one-cycle pulse per unexpected control char
		logic deskew_ok;         // level: deskew achieved
		logic initial_align_ok;  // level: initial lane alignment achieved
		logic config_checksum_ok;// level: config checksum correct
		logic frame_locked;      // level: frame sync held
		logic symbol_locked;     // level: code-group sync held
	} lls_lane_in_s;

	// status byte layout, bit 7 first
	typedef struct packed {
		logic disparity_err_flag;
		logic invalid_symbol_flag;
		logic stray_control_char_flag;
		logic deskew_ok;
		logic initial_align_ok;
		logic config_checksum_ok;
		logic frame_locked;
		logic symbol_locked;
	} lls_status_s;

endpackage : lls_pkg

// [rtl/lls_lane_monitor.sv]
// lane link status bank: one lane's error counters and status byte
`timescale 1ns/1ps
`include "lls_defines.svh"

module lls_lane_monitor #(
	parameter int CNT_W = `LLS_THR_W          // error counter width
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 count_clear,
	input  wire logic [CNT_W-1:0]     threshold,
	input  wire lls_pkg::lls_lane_in_s lane_in,
	output lls_pkg::lls_status_s      status_q,
	output logic                      changed_q
);

	logic [2:0]           err_evt;   // error pulses, disparity first
	logic [2:0]           flag_d;    // counter at or above threshold
	lls_pkg::lls_status_s status_d;  // next status byte

	assign err_evt = {lane_in.disp_err, lane_in.invalid_sym, lane_in.stray_ctrl};

	// one saturating counter per error kind, compared every cycle
	generate
		for (genvar k = 0; k < 3; k++) begin : g_cnt
			logic [CNT_W-1:0] cnt_q;  // error count
			// saturate so a long burst never wraps the flag back to 0
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cnt_q <= CNT_W'(`LLS_CNT_RST);
				end else if (count_clear) begin
					cnt_q <= '0;
				end else if (err_evt[k] && (cnt_q != '1)) begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
			assign flag_d[k] = (cnt_q >= threshold);
		end
	endgenerate

	// assemble the byte: flags in 7..5, sync levels in 4..0
	always_comb begin
		status_d                         = lls_pkg::lls_status_s'(`LLS_STATUS_RST);
		status_d.disparity_err_flag      = flag_d[2];
		status_d.invalid_symbol_flag     = flag_d[1];
		status_d.stray_control_char_flag = flag_d[0];
		status_d.deskew_ok               = lane_in.deskew_ok;
		status_d.initial_align_ok        = lane_in.initial_align_ok;
		status_d.config_checksum_ok      = lane_in.config_checksum_ok;
		status_d.frame_locked            = lane_in.frame_locked;
		status_d.symbol_locked           = lane_in.symbol_locked;
	end

	// status byte flop, reset to zero; changed pulses on any bit edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q  <= lls_pkg::lls_status_s'(`LLS_STATUS_RST);
			changed_q <= 1'b0;
		end else begin
			status_q  <= status_d;
			changed_q <= (status_d != status_q);
		end
	end

endmodule : lls_lane_monitor

// [test/lls_link_tx.sv]
// lane link status bank: transmitter-side model driving the per-lane datapath status
`timescale 1ns/1ps

module lls_link_tx #(
	parameter int NUM_LINKS = 2  // links modelled
) (
	input  wire logic [4:0]       lvl [NUM_LINKS][3], // sync levels per lane
	input  wire logic [2:0]       err [NUM_LINKS][3], // one-cycle error strobes
	output lls_pkg::lls_lane_in_s lane_in [NUM_LINKS][3]
);
	// strobes pass straight through: one request is exactly one errored symbol
	always_comb begin
		for (int k = 0; k < NUM_LINKS; k++) begin
			for (int n = 0; n < 3; n++) begin
				lane_in[k][n] = lls_pkg::lls_lane_in_s'({err[k][n], lvl[k][n]});
			end
		end
	end
endmodule : lls_link_tx

// [test/lls_bank_sva.sv]
// lane link status bank: bus and status checker
`timescale 1ns/1ps

module lls_bank_sva #(
	parameter int ADDR_W    = 16,
	parameter int NUM_LINKS = 2,
	parameter int PAGE_W    = 1
) (
	input wire logic aclk, aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr,
	input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic [31:0] s_axi_wdata, s_axi_rdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic [1:0] s_axi_bresp, s_axi_rresp,
	input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire logic s_axi_rvalid, s_axi_rready, irq, err_count_clear,
	input wire logic [PAGE_W-1:0] link_page,
	input wire logic [7:0] error_count_threshold,
	input wire lls_pkg::lls_lane_in_s lane_in [NUM_LINKS][3]
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// address and data both accepted at one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken(a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence
	// levels steady for two edges, so the status flop holds them at the take
	property p_lvl(a, int ln);
		s_rd_taken(a) ##0 ($past(aresetn) && $stable(link_page) && $stable(lane_in[link_page][ln][4:0]))
			|=> s_axi_rdata[4:0] == $past(lane_in[link_page][ln][4:0]);
	endproperty

	// both halves held at the take edge, answer raised one edge later
	a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("no write answer");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
	a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("outputs not cleared");
	a_flags_thr0: assert property (s_rd_taken(16'h12c8) ##0 (error_count_threshold == 8'h00 &&
		$past(error_count_threshold) == 8'h00 && $past(aresetn) && $past(aresetn, 2)) |=> s_axi_rdata[7:5] == 3'h7)
		else $error("flags low at zero threshold");
	a_lane1_level: assert property (p_lvl(16'h12c4, 0)) else $error("lane1 levels wrong");
	a_lane2_level: assert property (p_lvl(16'h12c8, 1)) else $error("lane2 levels wrong");
	a_lane3_level: assert property (p_lvl(16'h12cc, 2)) else $error("lane3 levels wrong");
endmodule : lls_bank_sva

bind lane_link_status_bank lls_bank_sva #(.ADDR_W(ADDR_W), .NUM_LINKS(NUM_LINKS), .PAGE_W(PAGE_W)) i_sva (.aclk,
	.aresetn,
	.s_axi_awaddr, .s_axi_araddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
	.s_axi_rdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq, .err_count_clear, .link_page, .error_count_threshold,
	.lane_in);

// [test/testbench.sv]
// lane link status bank: randomized self-checking testbench
`timescale 1ns/1ps
`include "lls_defines.svh"

module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, err_count_clear = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [0:0]  link_page = 1'b0;
	logic [7:0]  error_count_threshold = 8'h03;
	logic [4:0]  lvl [2][3];                // sync levels asked of the far side
	logic [2:0]  err [2][3];                // error strobes asked of the far side
	lls_pkg::lls_lane_in_s lane_in [2][3];
	int          cnt [2][3][3];             // errors sent per link, lane, kind
	int          n_mismatch = 0, n_checks = 0;
	logic [31:0] seed = 32'h83afb52e;
	logic [31:0] r;

	always #5 aclk = ~aclk;

	lane_link_status_bank #(.ADDR_W(16), .NUM_LINKS(2)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .link_page, .error_count_threshold, .err_count_clear, .lane_in, .irq);
	lls_link_tx #(.NUM_LINKS(2)) i_tx (.lvl, .err, .lane_in);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// expected byte: flags are count against threshold, levels as sent
	function automatic logic [31:0] exp_byte(int k, int n);
		logic [2:0] f;
		for (int e = 0; e < 3; e++) f[e] = cnt[k][n][e] >= error_count_threshold;
		return {24'h0, f, lvl[k][n]};
	endfunction : exp_byte

	function automatic logic [15:0] lane_addr(int n);
		return 16'((`LLS_IDX_LANE1 + n) * 4);
	endfunction : lane_addr

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk

	// a wait that ran out ends the run
	task automatic tmo(input int n);
		if (n >= 64) begin
			n_mismatch++;
			$display("unexpected handshake: expected answer seen none");
			summarize();
		end
	endtask : tmo

	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		int dly;
		@(posedge aclk);
		// bready held back 0..3 cycles so the answer must stand
		dly = int'(rnd() & 32'h3);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
			if (n >= dly) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		tmo(n);
		chk("write response", 32'(er), 32'(s_axi_bresp));
	endtask : wr

	task automatic rchk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		int dly;
		@(posedge aclk);
		// rready held back 0..3 cycles so the read data must stand
		dly = int'(rnd() & 32'h3);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
			if (n >= dly) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		tmo(n);
		chk("read data", e, s_axi_rdata);
		chk("read response", 32'(er), 32'(s_axi_rresp));
	endtask : rchk

	initial begin
		for (int k = 0; k < 2; k++) begin
			for (int n = 0; n < 3; n++) begin
				lvl[k][n] = 5'h00;
				err[k][n] = 3'h0;
				cnt[k][n] = '{0, 0, 0};
			end
		end
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int n = 0; n < 3; n++) rchk(lane_addr(n), 32'h0, `LLS_RESP_OKAY);
		wr(lane_addr(1), rnd(), `LLS_RESP_OKAY);
		rchk(lane_addr(1), 32'h0, `LLS_RESP_OKAY);
		rchk(16'h1300, 32'h0, `LLS_RESP_SLVERR);
		wr(16'h1300, 32'h0, `LLS_RESP_SLVERR);
		// interrupt: raise, mask, clear
		wr(16'h12e4, 32'h7, `LLS_RESP_OKAY);
		rchk(16'h12e4, 32'h7, `LLS_RESP_OKAY);
		rchk(16'h12e0, 32'h0, `LLS_RESP_OKAY);
		lvl[0][1] <= 5'h01;
		repeat (4) @(posedge aclk);
		chk("irq raised", 32'h1, 32'(irq));
		wr(16'h12e4, 32'h0, `LLS_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("irq masked", 32'h0, 32'(irq));
		rchk(16'h12e0, 32'h2, `LLS_RESP_OKAY);
		wr(16'h12e4, 32'h7, `LLS_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, 32'(irq));
		// random levels, error bursts, page and threshold
		for (int i = 0; i < 60; i++) begin
			@(posedge aclk);
			r = rnd();
			link_page <= r[0];
			error_count_threshold <= 8'(r[31:16] % 6);
			for (int k = 0; k < 2; k++) begin
				for (int n = 0; n < 3; n++) begin
					r = rnd();
					lvl[k][n] <= r[4:0];
					err[k][n] <= r[7:5] & r[10:8];
					for (int e = 0; e < 3; e++) if (r[5+e] & r[8+e] && cnt[k][n][e] < 255) cnt[k][n][e]++;
				end
			end
			@(posedge aclk);
			for (int k = 0; k < 2; k++) for (int n = 0; n < 3; n++) err[k][n] <= 3'h0;
			repeat (5) @(posedge aclk);
			for (int n = 0; n < 3; n++) rchk(lane_addr(n), exp_byte(link_page, n), `LLS_RESP_OKAY);
			// write the inverse of a live status byte; it must read back unchanged
			if (i == 10) begin
				wr(lane_addr(2), ~exp_byte(link_page, 2), `LLS_RESP_OKAY);
				rchk(lane_addr(2), exp_byte(link_page, 2), `LLS_RESP_OKAY);
			end
			if (i == 30) begin
				err_count_clear <= 1'b1;
				@(posedge aclk);
				err_count_clear <= 1'b0;
				for (int k = 0; k < 2; k++) for (int n = 0; n < 3; n++) cnt[k][n] = '{0, 0, 0};
			end
		end
		summarize();
	end
endmodule : testbench
